// [inc/nfc_consts.vh]
// Constants for the NAND flash host controller
// Notes on behaviour
// - Read and program send column then row cycles
// - Column in cycles one, two; row in three, four
// - Unused address bits and upper lines driven low
// - Erase sends only the two row cycles
// - Bus writes latched on write strobe rising edge
// - Latch strobes mark command, address, else data
// - Wide bus: commands, addresses on low byte only
// - Reset, status, identify are single-cycle commands
// - Page read: setup, four addresses, execute
// - Program: setup, addresses, data, confirm or cache
// - Erase: setup, two rows, confirm; whole block
// - Copy-back: special read, then new-address program
// - Random in/out move column inside page
// - During busy only reset and status allowed
// - Never issue an undefined command code
`ifndef NFC_CONSTS_VH
`define NFC_CONSTS_VH

// Device command codes
`define NFC_CMD_READ_SETUP 8'h00
`define NFC_CMD_READ_EXEC 8'h30
`define NFC_CMD_READ_COPY 8'h35
`define NFC_CMD_READ_ID 8'h90
`define NFC_CMD_RESET 8'hFF
`define NFC_CMD_PROG_SETUP 8'h80
`define NFC_CMD_PROG_CONF 8'h10
`define NFC_CMD_CACHE_CONF 8'h15
`define NFC_CMD_COPY_PROG 8'h85
`define NFC_CMD_ERASE_SETUP 8'h60
`define NFC_CMD_ERASE_CONF 8'hD0
`define NFC_CMD_RAND_OUT 8'h05
`define NFC_CMD_RAND_OUT_EXEC 8'hE0
`define NFC_CMD_STATUS 8'h70

// Operation codes written by software to the command register
`define NFC_OP_RESET 4'h0
`define NFC_OP_STATUS 4'h1
`define NFC_OP_READ_ID 4'h2
`define NFC_OP_PAGE_READ 4'h3
`define NFC_OP_COPY_READ 4'h4
`define NFC_OP_PROG_SETUP 4'h5
`define NFC_OP_PROG_CONF 4'h6
`define NFC_OP_CACHE_CONF 4'h7
`define NFC_OP_COPY_PROG 4'h8
`define NFC_OP_ERASE 4'h9
`define NFC_OP_RAND_IN 4'hA
`define NFC_OP_RAND_OUT 4'hB
`define NFC_OP_DATA_WR 4'hC
`define NFC_OP_DATA_RD 4'hD

// Register byte offsets
`define NFC_REG_CMD 8'h00
`define NFC_REG_COL 8'h04
`define NFC_REG_ROW 8'h08
`define NFC_REG_DATA 8'h0C
`define NFC_REG_STATUS 8'h10
`define NFC_REG_CFG 8'h14

// Field positions
`define NFC_ST_ACTIVE 0
`define NFC_ST_READY 1
`define NFC_ST_REFUSED 2
`define NFC_CFG_WIDE 0
`define NFC_CFG_WP_OFF 1

// Reset values
`define NFC_CFG_RST 2'h0
`define NFC_COL_RST 11'h000
`define NFC_ROW_RST 16'h0000

// Timing: times in ns, counts derived from the clock period
`define NFC_CLK_NS 20
`define NFC_T_STROBE_NS 40
`define NFC_T_RECOVER_NS 40
`define NFC_T_BUSY_ONSET_NS 100
`define NFC_CYC_STROBE ((`NFC_T_STROBE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_CYC_RECOVER ((`NFC_T_RECOVER_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_CYC_BUSY_ONSET ((`NFC_T_BUSY_ONSET_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
// Extra low time on reads covers the two-stage input synchroniser
`define NFC_CYC_SYNC 2

`endif

// [verif/nfc_flash_model.sv]
// Behavioural flash device on the far side of the controller
`timescale 1ns/1ps
module nfc_flash_model #(
  parameter int BUSY = 12,
  parameter int PON = 200
) (
  input logic clk_i,
  input logic ce_n_i,
  input logic cle_i,
  input logic ale_i,
  input logic we_n_i,
  input logic rs_n_i,
  input logic wp_n_i,
  input logic [15:0] io_i,
  output logic [15:0] dq_o,
  output logic rb_o
);
  logic [17:0] log_q [0:63];
  logic [15:0] page [0:15];
  logic [7:0] cmd = 8'h00;
  logic [10:0] col = 11'h000;
  int cnt = 0;
  int acnt = 0;
  int req = 0;
  int seen = 0;
  int bcnt = PON;
  // First page preloaded as by the power-on read
  initial begin
    for (int i = 0; i < 16; i++) page[i] = 16'hC000 + 16'(i);
    dq_o = 16'h5A5A;
  end
  // Latch on write strobe rising edge
  always @(posedge we_n_i) begin
    if (!ce_n_i) begin
      log_q[cnt] = {cle_i, ale_i, io_i};
      cnt++;
      if (cle_i && (rb_o || io_i[7:0] inside {8'hFF, 8'h70})) begin
        cmd = io_i[7:0];
        acnt = (cmd == 8'h60) ? 2 : 0;
        if (cmd inside {8'h30, 8'h35, 8'h10, 8'h15, 8'hD0, 8'hFF}) req++;
      end else if (ale_i) begin
        if (acnt == 0) col[7:0] = io_i[7:0];
        if (acnt == 1) col[10:8] = io_i[2:0];
        acnt++; // Surplus cycles change nothing
      end else if (!cle_i) begin
        page[col[3:0]] = io_i; // Cache fills even while busy
        col++;
      end
    end
  end
  // Falling read strobe gives next word
  always @(negedge rs_n_i) begin
    if (!ce_n_i) begin
      dq_o = (cmd == 8'h70) ? {8'h00, wp_n_i, rb_o, 6'h00} : page[col[3:0]];
      col++;
    end
  end
  // Released bus shows the inverse, never a stale word
  always @(posedge rs_n_i) dq_o = ~dq_o;
  // Busy timer; select release is ignored while busy
  always @(posedge clk_i) begin
    if (req != seen) begin
      bcnt <= BUSY;
      seen <= req;
    end else if (bcnt > 0) bcnt <= bcnt - 1;
  end
  assign rb_o = (bcnt == 0);
endmodule // nfc_flash_model

// [verif/nfc_host_assertions.sv]
// Pin and bus checker for the flash host controller
`timescale 1ns/1ps
module nfc_host_assertions (
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_ack_o,
  input logic ce_n_o,
  input logic cle_o,
  input logic ale_o,
  input logic we_n_o,
  input logic read_strobe_n_o,
  input logic [15:0] io_o,
  input logic io_oe_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Strobe low times of the chosen timing
  sequence s_we;
    !we_n_o [*2] ##1 we_n_o;
  endsequence
  sequence s_rs;
    !read_strobe_n_o [*4] ##1 read_strobe_n_o;
  endsequence
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("long ack");
  AST_UPPER_LOW: assert property ((cle_o || ale_o) && io_oe_o |-> io_o[15:8] == 8'h00)
    else $error("upper lines set");
  AST_LATCH_EXCL: assert property (!(cle_o && ale_o))
    else $error("both latches");
  AST_SELECTED: assert property (!we_n_o || !read_strobe_n_o |-> !ce_n_o)
    else $error("strobe unselected");
  AST_WE_HOLD: assert property ($rose(we_n_o) |-> io_oe_o && $stable({cle_o, ale_o, io_o}))
    else $error("bus moved at latch");
  AST_WE_LEN: assert property ($fell(we_n_o) |-> s_we)
    else $error("write strobe length");
  AST_RS_LEN: assert property ($fell(read_strobe_n_o) |-> s_rs)
    else $error("read strobe length");
  AST_RS_FREE: assert property (!read_strobe_n_o |-> !io_oe_o && !cle_o && !ale_o)
    else $error("bus driven on read");
endmodule // nfc_host_assertions

// [verif/testbench.sv]
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dw = 32'h0;
  logic [31:0] dr, rd;
  logic ce_n, cle, ale, we_n, rs_n, wp_n, oe, rb, ack;
  logic [15:0] io, dq;
  wire [15:0] io_bus = oe ? io : dq;
  int failures = 0;
  int checked = 0;
  // Clock of 20 ns
  always #10 clk_i = ~clk_i;
  nfc_host u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack_o(ack), .ce_n_o(ce_n), .cle_o(cle), .ale_o(ale), .we_n_o(we_n),
    .read_strobe_n_o(rs_n), .wp_n_o(wp_n), .io_o(io), .io_oe_o(oe), .io_i(io_bus), .rb_i(rb));
  nfc_flash_model u_dev (.clk_i(clk_i), .ce_n_i(ce_n), .cle_i(cle), .ale_i(ale),
    .we_n_i(we_n), .rs_n_i(rs_n), .wp_n_i(wp_n), .io_i(io_bus), .dq_o(dq), .rb_o(rb));
  // Expected latched cycles: command, address, data
  function automatic logic [17:0] c(input logic [7:0] v); return {10'h200, v}; endfunction
  function automatic logic [17:0] a(input logic [7:0] v); return {10'h100, v}; endfunction
  function automatic logic [17:0] d(input logic [15:0] v); return {2'b00, v}; endfunction
  wire [71:0] ad = {a(8'hA8), a(8'h05), a(8'hEF), a(8'hBE)};
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic stop();
    failures++;
    wrap_up();
  endtask
  // One classic cycle, held until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [7:0] ad_i, input logic [31:0] dt);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad_i;
    dw <= dt;
    // Ack and read data are taken at the rising edge that samples ack high
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      n++;
      if (n > 20) stop();
      @(posedge clk_i);
    end
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    // Request stays low for one full cycle before the next one
    @(posedge clk_i);
  endtask
  // Start an op, poll until idle, compare what the device latched
  task automatic op(input logic [3:0] cd, input int k, input logic [143:0] s);
    int b;
    int n;
    b = u_dev.cnt;
    n = 0;
    wb(1'b1, 8'h00, {28'h0, cd});
    wb(1'b0, 8'h10, 32'h0);
    while (rd[0] !== 1'b0) begin
      n++;
      if (n > 200) stop();
      wb(1'b0, 8'h10, 32'h0);
    end
    chk("cycles", u_dev.cnt - b, k);
    for (int i = 0; i < k; i++) chk("bus", u_dev.log_q[b + i], s[(k - 1 - i) * 18 +: 18]);
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("pins", {28'h0, ce_n, wp_n, we_n, rs_n}, 32'hB);
    for (int i = 0; i < 9; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0);
      chk("reg", rd, 32'h0);
    end
    $display("test reset values done");
    wb(1'b1, 8'h00, 32'h3);
    wb(1'b0, 8'h10, 32'h0);
    chk("busy refuse", rd, 32'h4);
    wb(1'b1, 8'h10, 32'h4);
    wb(1'b1, 8'h00, 32'hE);
    wb(1'b0, 8'h10, 32'h0);
    chk("bad op", rd, 32'h4);
    wb(1'b1, 8'h10, 32'h4);
    op(4'h1, 1, c(8'h70));
    wb(1'b0, 8'h0C, 32'h0);
    chk("status word", rd, 32'h0);
    op(4'h0, 1, c(8'hFF));
    chk("ready", rd, 32'h2);
    $display("test busy refusal done");
    wb(1'b1, 8'h14, 32'h2);
    chk("protect", {31'h0, wp_n}, 32'h1);
    wb(1'b1, 8'h04, 32'h5A8);
    wb(1'b1, 8'h08, 32'hBEEF);
    op(4'h3, 6, {c(8'h00), ad, c(8'h30)});
    op(4'h4, 6, {c(8'h00), ad, c(8'h35)});
    op(4'h5, 5, {c(8'h80), ad});
    wb(1'b1, 8'h0C, 32'h1234);
    op(4'hC, 1, d(16'h0034));
    op(4'h7, 1, c(8'h15));
    op(4'h5, 5, {c(8'h80), ad});
    op(4'h6, 1, c(8'h10));
    op(4'h8, 6, {c(8'h85), ad, c(8'h10)});
    op(4'h9, 4, {c(8'h60), ad[35:0], c(8'hD0)});
    op(4'hA, 3, {c(8'h85), ad[71:36]});
    $display("test command sequences done");
    wb(1'b1, 8'h04, 32'h8);
    op(4'hB, 4, {c(8'h05), a(8'h08), a(8'h00), c(8'hE0)});
    op(4'hD, 0, 144'h0);
    wb(1'b0, 8'h0C, 32'h0);
    chk("narrow read", rd, 32'h34);
    wb(1'b1, 8'h14, 32'h3);
    op(4'hD, 0, 144'h0);
    wb(1'b0, 8'h0C, 32'h0);
    chk("wide read", rd, 32'hC009);
    wb(1'b1, 8'h0C, 32'hABCD);
    op(4'hC, 1, d(16'hABCD));
    op(4'h2, 1, c(8'h90));
    $display("test data transfers done");
    wrap_up();
  end
endmodule // testbench
bind nfc_host nfc_host_assertions u_ast (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ce_n_o(ce_n_o),
  .cle_o(cle_o), .ale_o(ale_o), .we_n_o(we_n_o), .read_strobe_n_o(read_strobe_n_o),
  .io_o(io_o), .io_oe_o(io_oe_o));

// [verilog/nfc_host.v]
// NAND flash host controller with a Wishbone register port
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`include "nfc_consts.vh"
module nfc_host (
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Flash pins
  output reg ce_n_o,
  output reg cle_o,
  output reg ale_o,
  output reg we_n_o,
  output reg read_strobe_n_o,
  output reg wp_n_o,
  output reg [15:0] io_o,
  output reg io_oe_o,
  input wire [15:0] io_i,
  input wire rb_i
);
  // Sequencer states
  localparam ST_IDLE = 3'd0;
  localparam ST_SET = 3'd1;
  localparam ST_LO = 3'd2;
  localparam ST_HI = 3'd3;
  localparam ST_WB = 3'd4;
  localparam ST_RB = 3'd5;
  // Phases of one operation, in issue order
  localparam PH_CMD1 = 3'd0;
  localparam PH_ADDR = 3'd1;
  localparam PH_DATA = 3'd2;
  localparam PH_CMD2 = 3'd3;
  localparam PH_RB = 3'd4;
  localparam PH_END = 3'd5;

  reg [2:0] st_r;
  reg [2:0] ph_r;
  reg [1:0] aidx_r;
  reg [3:0] op_r;
  reg [3:0] cnt_r;
  reg [10:0] col_r;
  reg [15:0] row_r;
  reg [15:0] wdata_r;
  reg [15:0] rdata_r;
  reg [1:0] cfg_r;
  reg refused_r;
  wire [15:0] io_s;
  wire rb_s;

  // Pins cross into the clock domain through two flops
  nfc_sync #(.W(17)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({rb_i, io_i}),
    .q_o({rb_s, io_s})
  );

  wire wide = cfg_r[`NFC_CFG_WIDE];
  wire idle = (st_r == ST_IDLE);
  wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_cmd = acc & wb_we_i & (wb_adr_i == `NFC_REG_CMD) & wb_sel_i[0];
  wire [3:0] dec_op = idle ? wb_dat_i[3:0] : op_r;

  // Operation decode: which phases exist and what they carry
  reg d_valid;
  reg d_busy_ok;
  reg [7:0] d_cmd1;
  reg [7:0] d_cmd2;
  reg [5:0] d_pres;
  reg [1:0] d_a0;
  reg [1:0] d_alast;
  reg d_rd;
  always @* begin
    d_valid = 1'b1;
    d_busy_ok = 1'b0;
    d_cmd1 = `NFC_CMD_READ_SETUP;
    d_cmd2 = `NFC_CMD_READ_EXEC;
    d_pres = 6'h20;
    d_a0 = 2'd0;
    d_alast = 2'd3;
    d_rd = 1'b0;
    case (dec_op)
      `NFC_OP_RESET: begin
        d_cmd1 = `NFC_CMD_RESET;
        d_pres = 6'h31;
        d_busy_ok = 1'b1;
      end
      `NFC_OP_STATUS: begin
        d_cmd1 = `NFC_CMD_STATUS;
        d_pres = 6'h25;
        d_rd = 1'b1;
        d_busy_ok = 1'b1;
      end
      `NFC_OP_READ_ID: begin
        d_cmd1 = `NFC_CMD_READ_ID;
        d_pres = 6'h21;
      end
      `NFC_OP_PAGE_READ: begin
        d_pres = 6'h3B;
      end
      `NFC_OP_COPY_READ: begin
        d_cmd2 = `NFC_CMD_READ_COPY;
        d_pres = 6'h3B;
      end
      `NFC_OP_PROG_SETUP: begin
        d_cmd1 = `NFC_CMD_PROG_SETUP;
        d_pres = 6'h23;
      end
      `NFC_OP_PROG_CONF: begin
        d_cmd1 = `NFC_CMD_PROG_CONF;
        d_pres = 6'h31;
      end
      `NFC_OP_CACHE_CONF: begin
        d_cmd1 = `NFC_CMD_CACHE_CONF;
        d_pres = 6'h31;
      end
      `NFC_OP_COPY_PROG: begin
        d_cmd1 = `NFC_CMD_COPY_PROG;
        d_cmd2 = `NFC_CMD_PROG_CONF;
        d_pres = 6'h3B;
      end
      `NFC_OP_ERASE: begin
        d_cmd1 = `NFC_CMD_ERASE_SETUP;
        d_cmd2 = `NFC_CMD_ERASE_CONF;
        d_pres = 6'h3B;
        d_a0 = 2'd2;
      end
      `NFC_OP_RAND_IN: begin
        d_cmd1 = `NFC_CMD_COPY_PROG;
        d_pres = 6'h23;
        d_alast = 2'd1;
      end
      `NFC_OP_RAND_OUT: begin
        d_cmd1 = `NFC_CMD_RAND_OUT;
        d_cmd2 = `NFC_CMD_RAND_OUT_EXEC;
        d_pres = 6'h2B;
        d_alast = 2'd1;
      end
      `NFC_OP_DATA_WR: begin
        d_pres = 6'h24;
      end
      `NFC_OP_DATA_RD: begin
        d_pres = 6'h24;
        d_rd = 1'b1;
      end
      default: begin
        d_valid = 1'b0;
      end
    endcase
  end

  // Next present phase after the current one
  reg [2:0] nxt_ph;
  integer i;
  always @* begin
    nxt_ph = PH_END;
    for (i = 4; i >= 0; i = i - 1) begin
      if ((i > ph_r) && d_pres[i]) begin
        nxt_ph = i[2:0];
      end
    end
  end

  // First phase of a freshly started operation
  reg [2:0] first_ph;
  integer j;
  always @* begin
    first_ph = PH_END;
    for (j = 4; j >= 0; j = j - 1) begin
      if (d_pres[j]) begin
        first_ph = j[2:0];
      end
    end
  end

  // Address byte for the current cycle; unused bits stay low
  reg [7:0] abyte;
  always @* begin
    case (aidx_r)
      2'd0: abyte = col_r[7:0];
      2'd1: abyte = {5'h00, col_r[10:8]};
      2'd2: abyte = row_r[7:0];
      default: abyte = row_r[15:8];
    endcase
  end

  // Refusal: undefined op, controller active, or device busy
  wire start_ok = d_valid & idle & (rb_s | d_busy_ok);

  // Sequencer and pin drive
  always @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
      ph_r <= PH_END;
      aidx_r <= 2'd0;
      op_r <= `NFC_OP_RESET;
      cnt_r <= 4'h0;
      rdata_r <= 16'h0000;
      ce_n_o <= 1'b1;
      cle_o <= 1'b0;
      ale_o <= 1'b0;
      we_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
      io_o <= 16'h0000;
      io_oe_o <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          ce_n_o <= 1'b1;
          if (wr_cmd && start_ok) begin
            op_r <= wb_dat_i[3:0];
            ph_r <= first_ph;
            aidx_r <= d_a0;
            ce_n_o <= 1'b0;
            st_r <= ST_SET;
          end
        end
        ST_SET: begin
          cnt_r <= 4'h0;
          cle_o <= (ph_r == PH_CMD1) || (ph_r == PH_CMD2);
          ale_o <= (ph_r == PH_ADDR);
          io_oe_o <= !((ph_r == PH_DATA) && d_rd);
          case (ph_r)
            PH_CMD1: io_o <= {8'h00, d_cmd1};
            PH_CMD2: io_o <= {8'h00, d_cmd2};
            PH_ADDR: io_o <= {8'h00, abyte};
            default: io_o <= wide ? wdata_r : {8'h00, wdata_r[7:0]};
          endcase
          if (ph_r == PH_RB) begin
            st_r <= ST_WB;
          end else if (ph_r == PH_END) begin
            cle_o <= 1'b0;
            ale_o <= 1'b0;
            io_oe_o <= 1'b0;
            st_r <= ST_IDLE;
          end else if ((ph_r == PH_DATA) && d_rd) begin
            read_strobe_n_o <= 1'b0;
            st_r <= ST_LO;
          end else begin
            we_n_o <= 1'b0;
            st_r <= ST_LO;
          end
        end
        ST_LO: begin
          cnt_r <= cnt_r + 4'h1;
          if (!read_strobe_n_o) begin
            // Hold low long enough for data to pass the synchroniser
            if (cnt_r == `NFC_CYC_STROBE + `NFC_CYC_SYNC - 1) begin
              rdata_r <= wide ? io_s : {8'h00, io_s[7:0]};
              read_strobe_n_o <= 1'b1;
              cnt_r <= 4'h0;
              st_r <= ST_HI;
            end
          end else if (cnt_r == `NFC_CYC_STROBE - 1) begin
            we_n_o <= 1'b1;
            cnt_r <= 4'h0;
            st_r <= ST_HI;
          end
        end
        ST_HI: begin
          // Bus value held past the rising edge for hold time
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == `NFC_CYC_RECOVER - 1) begin
            st_r <= ST_SET;
            if ((ph_r == PH_ADDR) && (aidx_r != d_alast)) begin
              aidx_r <= aidx_r + 2'd1;
            end else begin
              ph_r <= nxt_ph;
            end
          end
        end
        ST_WB: begin
          // Ready/busy needs time to fall after the last command
          cnt_r <= cnt_r + 4'h1;
          cle_o <= 1'b0;
          io_oe_o <= 1'b0;
          if (cnt_r == `NFC_CYC_BUSY_ONSET - 1) begin
            st_r <= ST_RB;
          end
        end
        ST_RB: begin
          // Chip select stays low until ready returns
          if (rb_s) begin
            ph_r <= PH_END;
            st_r <= ST_SET;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Register writes and sticky refusal flag, set beats clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      col_r <= `NFC_COL_RST;
      row_r <= `NFC_ROW_RST;
      wdata_r <= 16'h0000;
      cfg_r <= `NFC_CFG_RST;
      refused_r <= 1'b0;
      wp_n_o <= 1'b0;
    end else begin
      wp_n_o <= cfg_r[`NFC_CFG_WP_OFF];
      if (acc && wb_we_i) begin
        case (wb_adr_i)
          `NFC_REG_COL: begin
            if (wb_sel_i[0]) col_r[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) col_r[10:8] <= wb_dat_i[10:8];
          end
          `NFC_REG_ROW: begin
            if (wb_sel_i[0]) row_r[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) row_r[15:8] <= wb_dat_i[15:8];
          end
          `NFC_REG_DATA: begin
            if (wb_sel_i[0]) wdata_r[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) wdata_r[15:8] <= wb_dat_i[15:8];
          end
          `NFC_REG_CFG: begin
            if (wb_sel_i[0]) cfg_r <= wb_dat_i[1:0];
          end
          `NFC_REG_STATUS: begin
            if (wb_sel_i[0] && wb_dat_i[`NFC_ST_REFUSED]) refused_r <= 1'b0;
          end
          default: begin
          end
        endcase
      end
      if (wr_cmd && !start_ok) begin
        refused_r <= 1'b1;
      end
    end
  end

  // Wishbone answer one cycle after the request; unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= 32'h00000000;
      if (acc && !wb_we_i) begin
        case (wb_adr_i)
          `NFC_REG_CMD: wb_dat_o <= {28'h0000000, op_r};
          `NFC_REG_COL: wb_dat_o <= {21'h0, col_r};
          `NFC_REG_ROW: wb_dat_o <= {16'h0000, row_r};
          `NFC_REG_DATA: wb_dat_o <= {16'h0000, rdata_r};
          `NFC_REG_STATUS: wb_dat_o <= {29'h0, refused_r, rb_s, !idle};
          `NFC_REG_CFG: wb_dat_o <= {30'h0, cfg_r};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // nfc_host

// [verilog/nfc_sync.v]
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module nfc_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_r;

  // First stage feeds only the second
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // nfc_sync
